// file: rtl/swc_config_bank.sv
// Configuration register bank of an eight-port switch, loaded from serial memory.
// Assumes a separate reader streams image bytes in after a load request.
//
// Contract
// - Source field picks duplex and speed origin
// - Stored mode, duplex bit high: full duplex
// - Stored mode, duplex bit low: half duplex
// - Stored mode, speed bit high: 100 Mb/s
// - Stored mode, speed bit low: 10 Mb/s
// - Disable bit stops pause frame transmission
// - Priority bit puts port in priority mode
// - Option bit makes pause use negotiation result
// - Upper range bit moves PHYs to 16-23
// - Reject bit drops all type frames
// - Backoff bit selects collision backoff algorithm
// - Five-bit gap length, default 21
// - Trunk A field encodes trunk grouping
// - Balance bit: source or destination spreading
// - Port zero internal link bit
// - IP priority check enable
// - Pause also applied to broadcast frames
// - Flood every frame to all ports
// - Broadcast throttle enable
// - Drop eight plus count broadcasts
// - Priority rate: very high or high
// - Load from serial memory after reset
// - Validate word gates each loaded register
`default_nettype none

module swc_config_bank
  import swc_pkg::*;
#(
  parameter int unsigned PORTS = NUM_PORTS
)
(
  // Clock, reset, enable
  input  wire logic                   clock_i,
  input  wire logic                   resetn_i,
  input  wire logic                   ce_i,
  // Image bytes from the serial memory reader
  input  wire logic                   load_valid_i,
  input  wire logic [7:0]             load_addr_i,
  input  wire logic [7:0]             load_data_i,
  input  wire logic                   load_done_i,
  output logic                        load_req_o,
  output logic                        config_ready_o,
  // Per-port link status
  input  wire swc_link_t [PORTS-1:0]  link_i,
  // Per-port resolved settings
  output swc_port_cfg_t [PORTS-1:0]   port_cfg_o,
  // MAC settings
  output logic [15:0]                 pause_time_o,
  output logic [4:0]                  phy_addr_base_o,
  output logic                        type_frame_reject_o,
  output logic                        even_backoff_sel_o,
  output logic [4:0]                  gap_length_o,
  // Trunk settings
  output logic [1:0]                  trunk_a_mode_o,
  output logic [3:0]                  trunk_a_members_o,
  output logic                        trunk_a_internal_o,
  output logic [1:0]                  trunk_b_mode_o,
  output logic                        balance_by_source_o,
  output logic                        port_zero_internal_link_o,
  // General settings
  output logic                        ip_prio_check_en_o,
  output logic                        pause_on_broadcast_en_o,
  output logic                        flood_everything_o,
  output logic                        broadcast_throttle_en_o,
  output logic [3:0]                  broadcast_drop_limit_o,
  output logic                        prio_rate_sel_o
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic is_valid(input logic [15:0] word, input int unsigned idx);
    is_valid = word[idx[3:0]];
  endfunction : is_valid

  function automatic logic [15:0] pair(input logic [7:0] hi, input logic [7:0] lo);
    pair = {hi, lo};
  endfunction : pair

  // ****************************************
  // Reset release
  // ****************************************
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ****************************************
  // Load sequence
  // ****************************************
  typedef enum logic [1:0] {ST_REQUEST, ST_COLLECT, ST_COMMIT, ST_RUN} swc_load_state_t;

  swc_load_state_t state;
  swc_load_state_t next_state;
  logic [7:0]      image [IMG_BYTES];

  always_comb
  begin
    case (state)
      ST_REQUEST: next_state = ST_COLLECT;
      ST_COLLECT: next_state = load_done_i ? ST_COMMIT : ST_COLLECT;
      ST_COMMIT:  next_state = ST_RUN;
      ST_RUN:     next_state = ST_RUN;
      default:    next_state = ST_REQUEST;
    endcase
  end

  // Every reset restarts the load
  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state          <= ST_REQUEST;
      load_req_o     <= 1'b0;
      config_ready_o <= 1'b0;
    end
    else if (ce_i)
    begin
      state          <= next_state;
      load_req_o     <= (state == ST_REQUEST);
      config_ready_o <= (state == ST_RUN);
    end
  end

  // Bytes are staged so a partial image never reaches the datapath
  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < IMG_BYTES; i++)
      begin
        image[i] <= 8'h00;
      end
    end
    else if (ce_i && state == ST_COLLECT && load_valid_i && load_addr_i <= ADDR_LAST)
    begin
      image[load_addr_i[3:0]] <= load_data_i;
    end
  end

  // ****************************************
  // Committed registers
  // ****************************************
  logic [15:0] load_validate_word;
  logic [15:0] pause_time;
  logic [7:0]  port_setup [PORTS];
  logic [15:0] mac_setup;
  logic [7:0]  trunk_setup;
  logic [7:0]  global_setup;
  logic [15:0] vld_img;

  assign vld_img = pair(image[ADDR_VALID_HI[3:0]], image[ADDR_VALID_LO[3:0]]) & VALID_USED;

  // Registers not validated keep their reset values
  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      load_validate_word <= VALID_RST;
      pause_time         <= PAUSE_RST;
      mac_setup          <= MAC_RST;
      trunk_setup        <= TRUNK_RST;
      global_setup       <= GLOBAL_RST;
      for (int p = 0; p < PORTS; p++)
      begin
        port_setup[p] <= PORT_RST;
      end
    end
    else if (ce_i && state == ST_COMMIT)
    begin
      load_validate_word <= vld_img;
      if (is_valid(vld_img, VLD_PAUSE))
      begin
        pause_time <= pair(image[ADDR_PAUSE_HI[3:0]], image[ADDR_PAUSE_LO[3:0]]);
      end
      for (int p = 0; p < PORTS; p++)
      begin
        if (is_valid(vld_img, VLD_PORT_BASE + p))
        begin
          port_setup[p] <= image[ADDR_PORT_BASE[3:0] + 4'(p)] & PORT_USED;
        end
      end
      if (is_valid(vld_img, VLD_MAC))
      begin
        mac_setup <= pair(image[ADDR_MAC_HI[3:0]], image[ADDR_MAC_LO[3:0]]) & MAC_USED;
      end
      if (is_valid(vld_img, VLD_TRUNK))
      begin
        trunk_setup <= image[ADDR_TRUNK[3:0]] & TRUNK_USED;
      end
      if (is_valid(vld_img, VLD_GLOBAL))
      begin
        global_setup <= image[ADDR_GLOBAL[3:0]] & GLOBAL_USED;
      end
    end
  end

  // ****************************************
  // Per-port resolution
  // ****************************************
  swc_port_cfg_t [PORTS-1:0] next_port_cfg;

  for (genvar g = 0; g < PORTS; g++)
  begin : g_port
    logic full;
    logic fast;

    swc_port_decode u_decode (
      .setup_i (port_setup[g]),
      .link_i  (link_i[g]),
      .full_o  (full),
      .fast_o  (fast)
    );

    always_comb
    begin
      next_port_cfg[g].full_duplex = full;
      next_port_cfg[g].fast        = fast;
      // Pause ability drops when disabled, or, with the option bit set, when negotiation refuses it
      next_port_cfg[g].pause_tx_en = !port_setup[g][PORT_PAUSE_DIS] &&
                                     (!mac_setup[MAC_OPTION] || link_i[g].partner_pause);
      next_port_cfg[g].prio        = port_setup[g][PORT_PRIO];
    end
  end

  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      port_cfg_o <= '0;
    end
    else if (ce_i)
    begin
      port_cfg_o <= next_port_cfg;
    end
  end

  // ****************************************
  // MAC and trunk outputs
  // ****************************************
  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pause_time_o              <= PAUSE_RST;
      phy_addr_base_o           <= PHY_BASE_LO;
      type_frame_reject_o       <= 1'b0;
      even_backoff_sel_o        <= 1'b0;
      gap_length_o              <= MAC_RST[MAC_GAP_LO +: 5];
      trunk_a_mode_o            <= TRK_NONE;
      trunk_a_members_o         <= 4'h0;
      trunk_a_internal_o        <= 1'b0;
      trunk_b_mode_o            <= TRK_NONE;
      balance_by_source_o       <= 1'b0;
      port_zero_internal_link_o <= 1'b0;
    end
    else if (ce_i)
    begin
      pause_time_o        <= pause_time;
      phy_addr_base_o     <= mac_setup[MAC_UPPER_PHY] ? PHY_BASE_HI : PHY_BASE_LO;
      type_frame_reject_o <= mac_setup[MAC_REJECT];
      even_backoff_sel_o  <= mac_setup[MAC_BACKOFF];
      gap_length_o        <= mac_setup[MAC_GAP_LO +: 5];
      trunk_a_mode_o      <= trunk_setup[TRK_A_LO +: 2];
      case (trunk_setup[TRK_A_LO +: 2])
        TRK_EXT_01:
        begin
          trunk_a_members_o  <= 4'h3;
          trunk_a_internal_o <= 1'b0;
        end
        TRK_EXT_03:
        begin
          trunk_a_members_o  <= 4'hf;
          trunk_a_internal_o <= 1'b0;
        end
        TRK_INT_01:
        begin
          trunk_a_members_o  <= 4'h3;
          trunk_a_internal_o <= 1'b1;
        end
        default:
        begin
          trunk_a_members_o  <= 4'h0;
          trunk_a_internal_o <= 1'b0;
        end
      endcase
      trunk_b_mode_o            <= trunk_setup[TRK_B_LO +: 2];
      balance_by_source_o       <= trunk_setup[TRK_BALANCE];
      port_zero_internal_link_o <= trunk_setup[TRK_P0_LINK];
    end
  end

  // ****************************************
  // General outputs
  // ****************************************
  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ip_prio_check_en_o      <= 1'b0;
      pause_on_broadcast_en_o <= 1'b0;
      flood_everything_o      <= 1'b0;
      broadcast_throttle_en_o <= 1'b0;
      broadcast_drop_limit_o  <= DROP_BASE;
      prio_rate_sel_o         <= 1'b0;
    end
    else if (ce_i)
    begin
      ip_prio_check_en_o      <= global_setup[GEN_IP_PRIO];
      pause_on_broadcast_en_o <= global_setup[GEN_PAUSE_BC];
      flood_everything_o      <= global_setup[GEN_FLOOD];
      broadcast_throttle_en_o <= global_setup[GEN_THROTTLE];
      broadcast_drop_limit_o  <= DROP_BASE + {1'b0, global_setup[GEN_DROP_LO +: 3]};
      prio_rate_sel_o         <= global_setup[GEN_PRIO_RATE];
    end
  end

endmodule : swc_config_bank

`default_nettype wire

// file: rtl/swc_pkg.sv
// Constants, field layouts and carrier types of the switch configuration bank.
// Assumes a single clock domain; the serial memory reader lives elsewhere.
`default_nettype none

package swc_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int unsigned NUM_PORTS = 8;
  localparam int unsigned IMG_BYTES = 16;

  // ****************************************
  // Byte addresses of the memory image
  // ****************************************
  localparam logic [7:0] ADDR_VALID_HI  = 8'h00;
  localparam logic [7:0] ADDR_VALID_LO  = 8'h01;
  localparam logic [7:0] ADDR_PAUSE_HI  = 8'h02;
  localparam logic [7:0] ADDR_PAUSE_LO  = 8'h03;
  localparam logic [7:0] ADDR_PORT_BASE = 8'h04;
  localparam logic [7:0] ADDR_MAC_HI    = 8'h0c;
  localparam logic [7:0] ADDR_MAC_LO    = 8'h0d;
  localparam logic [7:0] ADDR_TRUNK     = 8'h0e;
  localparam logic [7:0] ADDR_GLOBAL    = 8'h0f;
  localparam logic [7:0] ADDR_LAST      = 8'h0f;

  // ****************************************
  // Validate word bit positions
  // ****************************************
  localparam int unsigned VLD_PAUSE     = 0;
  localparam int unsigned VLD_PORT_BASE = 1;
  localparam int unsigned VLD_MAC       = 9;
  localparam int unsigned VLD_TRUNK     = 10;
  localparam int unsigned VLD_GLOBAL    = 11;

  // ****************************************
  // Values after reset
  // ****************************************
  localparam logic [15:0] VALID_RST  = 16'h0000;
  localparam logic [15:0] PAUSE_RST  = 16'h0600;
  localparam logic [7:0]  PORT_RST   = 8'h00;
  localparam logic [15:0] MAC_RST    = 16'h0015;
  localparam logic [7:0]  TRUNK_RST  = 8'h00;
  localparam logic [7:0]  GLOBAL_RST = 8'h00;

  // ****************************************
  // Implemented bits; the rest hold zero
  // ****************************************
  localparam logic [15:0] VALID_USED  = 16'h0fff;
  localparam logic [7:0]  PORT_USED   = 8'hfc;
  localparam logic [15:0] MAC_USED    = 16'h01ff;
  localparam logic [7:0]  TRUNK_USED  = 8'hfc;
  localparam logic [7:0]  GLOBAL_USED = 8'hff;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int unsigned PORT_MODE_LO   = 6;
  localparam int unsigned PORT_DUPLEX    = 5;
  localparam int unsigned PORT_SPEED     = 4;
  localparam int unsigned PORT_PAUSE_DIS = 3;
  localparam int unsigned PORT_PRIO      = 2;
  localparam int unsigned MAC_OPTION     = 8;
  localparam int unsigned MAC_UPPER_PHY  = 7;
  localparam int unsigned MAC_REJECT     = 6;
  localparam int unsigned MAC_BACKOFF    = 5;
  localparam int unsigned MAC_GAP_LO     = 0;
  localparam int unsigned TRK_A_LO       = 6;
  localparam int unsigned TRK_B_LO       = 4;
  localparam int unsigned TRK_BALANCE    = 3;
  localparam int unsigned TRK_P0_LINK    = 2;
  localparam int unsigned GEN_IP_PRIO    = 7;
  localparam int unsigned GEN_PAUSE_BC   = 6;
  localparam int unsigned GEN_FLOOD      = 5;
  localparam int unsigned GEN_DROP_LO    = 2;
  localparam int unsigned GEN_THROTTLE   = 1;
  localparam int unsigned GEN_PRIO_RATE  = 0;

  // ****************************************
  // Encodings
  // ****************************************
  localparam logic [1:0] MODE_STRAP  = 2'h0;
  localparam logic [1:0] MODE_ANEG   = 2'h1;
  localparam logic [1:0] MODE_STORED = 2'h2;
  localparam logic [1:0] MODE_MIXED  = 2'h3;
  localparam logic [1:0] TRK_NONE    = 2'h0;
  localparam logic [1:0] TRK_EXT_01  = 2'h1;
  localparam logic [1:0] TRK_EXT_03  = 2'h2;
  localparam logic [1:0] TRK_INT_01  = 2'h3;
  localparam logic [3:0] DROP_BASE   = 4'h8;
  localparam logic [4:0] PHY_BASE_LO = 5'h00;
  localparam logic [4:0] PHY_BASE_HI = 5'h10;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic strap_full;
    logic an_full;
    logic an_fast;
    logic det_fast;
    logic partner_pause;
  } swc_link_t;

  typedef struct packed {
    logic full_duplex;
    logic fast;
    logic pause_tx_en;
    logic prio;
  } swc_port_cfg_t;

endpackage : swc_pkg

`default_nettype wire

// file: rtl/swc_port_decode.sv
// Resolves one port's duplex and speed from its setup byte and link status.
// Combinational; the caller registers the results.
`default_nettype none

module swc_port_decode
  import swc_pkg::*;
(
  // Setup and link status
  input  wire logic [7:0] setup_i,
  input  wire swc_link_t  link_i,
  // Resolved operating point
  output logic            full_o,
  output logic            fast_o
);

  logic [1:0] mode;

  assign mode = setup_i[PORT_MODE_LO +: 2];

  always_comb
  begin
    case (mode)
      MODE_STRAP:
      begin
        full_o = link_i.strap_full;
        fast_o = link_i.det_fast;
      end
      MODE_ANEG:
      begin
        full_o = link_i.an_full;
        fast_o = link_i.an_fast;
      end
      MODE_STORED:
      begin
        full_o = setup_i[PORT_DUPLEX];
        fast_o = setup_i[PORT_SPEED];
      end
      MODE_MIXED:
      begin
        full_o = link_i.an_full;
        fast_o = link_i.det_fast;
      end
      default:
      begin
        full_o = link_i.strap_full;
        fast_o = link_i.det_fast;
      end
    endcase
  end

endmodule : swc_port_decode

`default_nettype wire

// file: tb/swc_config_props.sv
// Concurrent checks on the configuration bank ports.
// Assumes binding to swc_config_bank; one clock domain.
`default_nettype none

module swc_config_props
  import swc_pkg::*;
#(
  parameter int unsigned PORTS = NUM_PORTS
)
(
  // Clock, reset, enable
  input wire logic                      clock_i,
  input wire logic                      resetn_i,
  input wire logic                      ce_i,
  // Load handshake
  input wire logic                      load_done_i,
  input wire logic                      load_req_o,
  input wire logic                      config_ready_o,
  // Status and settings
  input wire swc_link_t [PORTS-1:0]     link_i,
  input wire swc_port_cfg_t [PORTS-1:0] port_cfg_o,
  input wire logic [15:0]               pause_time_o,
  input wire logic [4:0]                phy_addr_base_o,
  input wire logic                      type_frame_reject_o,
  input wire logic [4:0]                gap_length_o,
  input wire logic [1:0]                trunk_a_mode_o,
  input wire logic                      trunk_a_internal_o,
  input wire logic [3:0]                broadcast_drop_limit_o
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  // ****************
  // Helper state
  // ****************
  // Counts edges since release; the bank starts two edges late
  logic [1:0] up;
  logic       armed;
  logic       done_take;

  assign done_take = armed && load_done_i && ce_i && !config_ready_o;

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i) up <= 2'h0;
    else if (up != 2'h3) up <= up + 2'h1;
  end

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i) armed <= 1'b0;
    else if (done_take) armed <= 1'b0;
    else if (load_req_o) armed <= 1'b1;
  end

  sequence pre_cfg_s;
    ce_i && !config_ready_o && up == 2'h3;
  endsequence

  sequence commit_s;
    done_take ##1 ce_i ##1 ce_i;
  endsequence

  // ****************
  // Assertions
  // ****************
  req_single_a:
    assert property (load_req_o && ce_i |=> !load_req_o) else $error("load request too long");
  req_start_a:
    assert property (up == 2'h2 && ce_i |-> ##[1:3] load_req_o) else $error("no load request");
  commit_time_a:
    assert property (commit_s |=> config_ready_o) else $error("ready late");
  commit_wait_a:
    assert property (done_take |=> !config_ready_o) else $error("ready early");
  ready_hold_a:
    assert property (config_ready_o |=> config_ready_o) else $error("ready dropped");
  idle_vals_a:
    assert property (!config_ready_o |-> gap_length_o == 5'h15 && broadcast_drop_limit_o == 4'h8
                     && pause_time_o == 16'h0600) else $error("default lost");
  phy_idle_a:
    assert property (!config_ready_o |-> phy_addr_base_o == 5'h00 && !type_frame_reject_o)
      else $error("mac default lost");
  phy_range_a:
    assert property (phy_addr_base_o[3:0] == 4'h0) else $error("phy base off range");
  drop_range_a:
    assert property (broadcast_drop_limit_o[3]) else $error("drop limit below eight");
  trunk_int_a:
    assert property (trunk_a_internal_o == (trunk_a_mode_o == 2'h3)) else $error("trunk kind wrong");
  strap_path_a:
    assert property (pre_cfg_s ##1 !config_ready_o |-> port_cfg_o[0] ==
                     {$past(link_i[0].strap_full), $past(link_i[0].det_fast), 2'h2})
      else $error("strap decode wrong");
  prio_hold_a:
    assert property (config_ready_o && ce_i |=> $stable(port_cfg_o[0].prio)) else $error("prio moved");

endmodule : swc_config_props

`default_nettype wire

// file: tb/swc_mem_model.sv
// Behavioural serial memory reader streaming one image into the bank.
// Assumes the bank's clock and clock enable.
`default_nettype none

module swc_mem_model
  import swc_pkg::*;
(
  // Clock, reset, enable
  input  wire logic             clock_i,
  input  wire logic             resetn_i,
  input  wire logic             ce_i,
  // Control
  input  wire logic             load_req_i,
  input  wire logic             slow_i,
  input  wire logic [15:0][7:0] image_i,
  // Byte stream
  output logic                  load_valid_o,
  output logic [7:0]            load_addr_o,
  output logic [7:0]            load_data_o,
  output logic                  load_done_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic       active;
  logic       idle;
  logic [4:0] idx;
  logic [7:0] byte_val;

  // ****************
  // Sequencer
  // ****************
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      active <= 1'b0;
      idle   <= 1'b0;
      idx    <= 5'h00;
    end
    else if (ce_i && load_req_i)
    begin
      active <= 1'b1;
      idle   <= 1'b1;
      idx    <= 5'h00;
    end
    else if (ce_i && active)
    begin
      idle <= !idle && slow_i;
      if (!idle) idx <= idx + 5'h01;
      if (!idle && idx == 5'h11) active <= 1'b0;
    end
  end

  // Address 0x10 is past the image and must be ignored
  assign byte_val     = idx[4] ? 8'hff : image_i[idx[3:0]];
  assign load_valid_o = active && !idle && idx != 5'h11;
  assign load_done_o  = active && !idle && idx == 5'h11;
  // Released lines show the inverse so a stale byte never looks valid
  assign load_addr_o  = load_valid_o ? {3'h0, idx} : ~{3'h0, idx};
  assign load_data_o  = load_valid_o ? byte_val : ~byte_val;

endmodule : swc_mem_model

`default_nettype wire

// file: tb/tb.sv
// Self-checking bench for the switch configuration bank.
// Assumes the reader model and the bound port checker.
`default_nettype none

module tb
  import swc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic                          clock_i;
  logic                          resetn_i;
  logic                          ce_i;
  logic                          slow;
  logic                          load_valid;
  logic                          load_done;
  logic                          load_req;
  logic                          ready;
  logic [7:0]                    load_addr;
  logic [7:0]                    load_data;
  logic [15:0][7:0]              img;
  swc_link_t [NUM_PORTS-1:0]     link;
  swc_port_cfg_t [NUM_PORTS-1:0] pcfg;
  logic [15:0]                   pause_time;
  logic [4:0]                    phy_base;
  logic [4:0]                    gap;
  logic [1:0]                    ta_mode;
  logic [1:0]                    tb_mode;
  logic [3:0]                    ta_mem;
  logic [3:0]                    drop;
  logic                          reject;
  logic                          backoff;
  logic                          ta_int;
  logic                          bal;
  logic                          p0;
  logic                          ipc;
  logic                          pbc;
  logic                          flood;
  logic                          thr;
  logic                          rate;
  logic [15:0]                   vw;
  logic [15:0]                   mac;
  logic [7:0]                    tr;
  logic [7:0]                    gen;
  int                            err_total;
  int                            check_count;
  int                            cyc;

  swc_mem_model mem (
    .clock_i(clock_i), .resetn_i(resetn_i), .ce_i(ce_i), .load_req_i(load_req), .slow_i(slow),
    .image_i(img), .load_valid_o(load_valid), .load_addr_o(load_addr), .load_data_o(load_data),
    .load_done_o(load_done));

  swc_config_bank dut (
    .clock_i(clock_i), .resetn_i(resetn_i), .ce_i(ce_i), .load_valid_i(load_valid),
    .load_addr_i(load_addr), .load_data_i(load_data), .load_done_i(load_done), .load_req_o(load_req),
    .config_ready_o(ready), .link_i(link), .port_cfg_o(pcfg), .pause_time_o(pause_time),
    .phy_addr_base_o(phy_base), .type_frame_reject_o(reject), .even_backoff_sel_o(backoff),
    .gap_length_o(gap), .trunk_a_mode_o(ta_mode), .trunk_a_members_o(ta_mem),
    .trunk_a_internal_o(ta_int), .trunk_b_mode_o(tb_mode), .balance_by_source_o(bal),
    .port_zero_internal_link_o(p0), .ip_prio_check_en_o(ipc), .pause_on_broadcast_en_o(pbc),
    .flood_everything_o(flood), .broadcast_throttle_en_o(thr), .broadcast_drop_limit_o(drop),
    .prio_rate_sel_o(rate));

  // ****************
  // Helpers
  // ****************
  initial
  begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done

  // Ceiling well above the several hundred cycles the run needs
  always @(posedge clock_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      test_done();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  function automatic swc_port_cfg_t exp_port(input int p);
    logic [7:0]    s;
    swc_port_cfg_t r;
    s = vw[1 + p] ? img[4 + p] & 8'hfc : 8'h00;
    case (s[7:6])
      MODE_STRAP:  {r.full_duplex, r.fast} = {link[p].strap_full, link[p].det_fast};
      MODE_ANEG:   {r.full_duplex, r.fast} = {link[p].an_full, link[p].an_fast};
      MODE_STORED: {r.full_duplex, r.fast} = {s[5], s[4]};
      default:     {r.full_duplex, r.fast} = {link[p].an_full, link[p].det_fast};
    endcase
    r.pause_tx_en = !s[3] && (!mac[8] || link[p].partner_pause);
    r.prio = s[2];
    return r;
  endfunction : exp_port

  task automatic rst();
    resetn_i = 1'b0;
    repeat (16) @(posedge clock_i);
    #1;
    chk(pause_time, 16'h0600);
    chk(gap, 16'h0015);
    chk(drop, 16'h0008);
    chk(phy_base, 16'h0000);
    foreach (pcfg[p]) chk(pcfg[p], 16'h0000);
    resetn_i = 1'b1;
  endtask : rst

  task automatic glob_chk();
    vw  = {img[0], img[1]} & 16'h0fff;
    mac = vw[9] ? {img[12], img[13]} & 16'h01ff : 16'h0015;
    tr  = vw[10] ? img[14] & 8'hfc : 8'h00;
    gen = vw[11] ? img[15] : 8'h00;
    chk(pause_time, vw[0] ? {img[2], img[3]} : 16'h0600);
    chk(phy_base, mac[7] ? 5'h10 : 5'h00);
    chk(reject, mac[6]);
    chk(backoff, mac[5]);
    chk(gap, mac[4:0]);
    chk(ta_mode, tr[7:6]);
    chk(ta_mem, tr[7:6] == TRK_NONE ? 4'h0 : tr[7:6] == TRK_EXT_03 ? 4'hf : 4'h3);
    chk(ta_int, tr[7:6] == TRK_INT_01);
    chk(tb_mode, tr[5:4]);
    chk(bal, tr[3]);
    chk(p0, tr[2]);
    chk(ipc, gen[7]);
    chk(pbc, gen[6]);
    chk(flood, gen[5]);
    chk(thr, gen[1]);
    chk(drop, 4'h8 + gen[4:2]);
    chk(rate, gen[0]);
  endtask : glob_chk

  // ****************
  // Main sequence
  // ****************
  initial
  begin
    logic seen;
    resetn_i    = 1'b0;
    ce_i        = 1'b1;
    slow        = 1'b0;
    img         = '0;
    link        = '0;
    err_total   = 0;
    check_count = 0;
    cyc         = 0;
    void'($urandom(32'h2363));
    for (int it = 0; it < 8; it++)
    begin
      foreach (img[k]) img[k] = 8'($urandom());
      img[14][7:6] = 2'(it);
      if (it == 0) {img[0], img[1]} = 16'hffff;
      if (it == 1) {img[0], img[1]} = 16'h0000;
      slow = it[0];
      // Abort one load eight cycles after reset release, two bytes into the stream
      if (it == 3)
      begin
        rst();
        repeat (8) @(posedge clock_i);
        #1;
      end
      rst();
      seen = 1'b0;
      repeat (300)
      begin
        @(posedge clock_i);
        #1;
        ce_i = (seen && it > 4) ? ($urandom_range(0, 3) != 0) : 1'b1;
        if (load_req) seen = 1'b1;
        if (ready) break;
      end
      ce_i = 1'b1;
      chk(ready, 16'h0001);
      glob_chk();
      repeat (20)
      begin
        foreach (link[p]) link[p] = 5'($urandom());
        @(posedge clock_i);
        #1;
        foreach (pcfg[p]) chk(pcfg[p], exp_port(p));
      end
    end
    test_done();
  end

endmodule : tb

bind swc_config_bank swc_config_props #(.PORTS(PORTS)) u_props (
  .clock_i(clock_i), .resetn_i(resetn_i), .ce_i(ce_i), .load_done_i(load_done_i),
  .load_req_o(load_req_o), .config_ready_o(config_ready_o), .link_i(link_i), .port_cfg_o(port_cfg_o),
  .pause_time_o(pause_time_o), .phy_addr_base_o(phy_addr_base_o),
  .type_frame_reject_o(type_frame_reject_o), .gap_length_o(gap_length_o),
  .trunk_a_mode_o(trunk_a_mode_o), .trunk_a_internal_o(trunk_a_internal_o),
  .broadcast_drop_limit_o(broadcast_drop_limit_o));

`default_nettype wire
